// >>> hdl/phw_pkg.sv
package phw_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // register addresses (6-bit register space)
   localparam logic [5:0] REG_CTRL = 6'h07;
   localparam logic [5:0] REG_MODE = 6'h21;
   localparam logic [5:0] REG_TX_START_LO = 6'h22;
   localparam logic [5:0] REG_TX_START_HI = 6'h23;
   localparam logic [5:0] REG_RX_START_LO = 6'h24;
   localparam logic [5:0] REG_RX_START_HI = 6'h25;
   localparam logic [5:0] REG_STATUS = 6'h3e;

   ////////////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int CTRL_HIGH_RATE_BIT = 3;
   localparam int MODE_DBL_BIT = 0;
   localparam int MODE_TRI_BIT = 1;
   localparam int MODE_FMT_LSB = 2;
   localparam int MODE_EN_BIT = 5;
   localparam int STAT_PCM_BIT = 0;
   localparam int STAT_LOCK_BIT = 1;
   localparam int STAT_TX_BIT = 2;
   localparam int STAT_RX_BIT = 3;

   ////////////////////////////////////////////////////////////////////////////////
   // values after reset
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [9:0] START_RESET = 10'h000;

   ////////////////////////////////////////////////////////////////////////////////
   // sample formats and code constants
   localparam logic [1:0] FMT_MULAW = 2'h0;
   localparam logic [1:0] FMT_ALAW = 2'h1;
   localparam logic [1:0] FMT_LINEAR = 2'h3;
   localparam logic [7:0] ALAW_XOR = 8'h55;
   localparam logic [15:0] MU_BIAS = 16'h0021;
   localparam logic [15:0] MU_DEC_BIAS = 16'h0084;
   localparam logic [15:0] A_DEC_OFFSET = 16'h0100;
   localparam logic [15:0] MU_MAG_MAX = 16'h1fff;
   localparam logic [15:0] A_MAG_MAX = 16'h0fff;

   ////////////////////////////////////////////////////////////////////////////////
   // bit counts per frame and cycle counter limit
   localparam logic [5:0] BITS_COMP = 6'h08;
   localparam logic [5:0] BITS_COMP_HR = 6'h10;
   localparam logic [5:0] BITS_LIN = 6'h10;
   localparam logic [5:0] BITS_LIN_HR = 6'h20;
   localparam logic [10:0] CNT_MAX = 11'h7ff;

   typedef struct packed {
      logic [15:0] first;
      logic [15:0] second;
   } phw_sample_pair_t;

   typedef struct packed {
      logic addrWrite;
      logic addrRead;
      logic [5:0] addr;
      logic [7:0] wrData;
   } phw_reg_req_t;

endpackage

// >>> hdl/phw_compand_enc.sv
module phw_compand_enc (
   // law select and linear sample
   input wire logic aLaw,
   input wire logic [15:0] sample,
   // companded code
   output logic [7:0] code
);
   import phw_pkg::*;

   logic neg;
   logic [15:0] absv;
   logic [15:0] mag;
   logic [15:0] tmp;
   logic [2:0] seg;

   always_comb begin
      neg = sample[15];
      absv = neg ? 16'(~sample + 16'h0001) : sample;
      seg = 3'h0;
      if (!aLaw) begin
         // mu-law: biased 14-bit magnitude, clamped so the top segment saturates
         mag = {2'h0, absv[15:2]} + MU_BIAS;
         if (mag > MU_MAG_MAX) mag = MU_MAG_MAX;
         for (int i = 1; i < 8; i++) begin
            if (mag[i + 5]) seg = i[2:0];
         end
         // widened so the top segment shifts by eight instead of wrapping to zero
         tmp = mag >> (4'(seg) + 4'h1);
         code = ~{neg, seg, tmp[3:0]};
      end else begin
         mag = {3'h0, absv[15:3]};
         if (mag > A_MAG_MAX) mag = A_MAG_MAX;
         for (int i = 1; i < 8; i++) begin
            if (mag[i + 4]) seg = i[2:0];
         end
         tmp = (seg == 3'h0) ? (mag >> 1) : (mag >> seg);
         code = {~neg, seg, tmp[3:0]} ^ ALAW_XOR;
      end
   end

endmodule

// >>> hdl/phw_compand_dec.sv
module phw_compand_dec (
   // law select and companded code
   input wire logic aLaw,
   input wire logic [7:0] code,
   // linear sample
   output logic [15:0] sample
);
   import phw_pkg::*;

   logic [7:0] c;
   logic [15:0] mag;

   always_comb begin
      if (!aLaw) begin
         c = ~code;
         mag = ((({8'h00, 1'b0, c[3:0], 3'h0}) + MU_DEC_BIAS) << c[6:4]) - MU_DEC_BIAS;
         sample = c[7] ? 16'(~mag + 16'h0001) : mag;
      end else begin
         c = code ^ ALAW_XOR;
         if (c[6:4] == 3'h0) begin
            mag = {8'h00, c[3:0], 4'h8};
         end else begin
            mag = ({8'h00, c[3:0], 4'h8} + A_DEC_OFFSET) << (c[6:4] - 3'h1);
         end
         sample = c[7] ? mag : 16'(~mag + 16'h0001);
      end
   end

endmodule

// >>> hdl/phw_port.sv
module phw_port (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // mode strap
   input wire logic modeStrap,
   // register access
   input phw_pkg::phw_reg_req_t regReq,
   output logic [7:0] regRdData,
   // highway pins
   input wire logic bitClk,
   input wire logic frameSync,
   input wire logic rxDataIn,
   output logic txDataOut,
   output logic txDataOe_n,
   // sample side
   input phw_pkg::phw_sample_pair_t txSamples,
   output logic txTake,
   output phw_pkg::phw_sample_pair_t rxSamples,
   output logic rxValid
);
   import phw_pkg::*;

   typedef struct packed {
      logic clkS1;
      logic clkS2;
      logic clkPrev;
      logic fsS1;
      logic fsS2;
      logic rxS1;
      logic rxS2;
      logic strapS1;
      logic strapS2;
      logic strapTaken;
      logic pcmMode;
      logic fsAtRise;
      logic frameSeen;
      logic frameLocked;
      logic [10:0] cycleCnt;
      logic [10:0] frameLen;
      logic [7:0] ctrl;
      logic [7:0] mode;
      logic [9:0] txStart;
      logic [9:0] rxStart;
      logic txBusy;
      logic txPhase;
      logic [5:0] txLeft;
      logic [31:0] txShift;
      logic txData;
      logic txOe_n;
      logic txTake;
      logic rxBusy;
      logic rxPhase;
      logic [5:0] rxLeft;
      logic [31:0] rxShift;
      logic rxDone;
      phw_sample_pair_t rxSamples;
      logic rxValid;
      logic [7:0] rdData;
   } phw_state_t;

   phw_state_t st;
   phw_state_t next_st;

   logic [7:0] encFirst;
   logic [7:0] encSecond;
   logic [15:0] decFirst;
   logic [15:0] decSecond;
   logic aLawSel;
   logic linearSel;
   logic highRate;
   logic dblClk;
   logic [7:0] decInFirst;

   ////////////////////////////////////////////////////////////////////////////////
   // companding, one converter per sample of a frame

   assign aLawSel = st.mode[MODE_FMT_LSB +: 2] == FMT_ALAW;
   assign linearSel = st.mode[MODE_FMT_LSB +: 2] == FMT_LINEAR;
   assign highRate = st.ctrl[CTRL_HIGH_RATE_BIT];
   assign dblClk = st.mode[MODE_DBL_BIT];
   // with two codes the first sits one byte above the second
   assign decInFirst = highRate ? st.rxShift[15:8] : st.rxShift[7:0];

   phw_compand_enc encA (
      .aLaw(aLawSel),
      .sample(txSamples.first),
      .code(encFirst)
   );

   phw_compand_enc encB (
      .aLaw(aLawSel),
      .sample(txSamples.second),
      .code(encSecond)
   );

   phw_compand_dec decA (
      .aLaw(aLawSel),
      .code(decInFirst),
      .sample(decFirst)
   );

   phw_compand_dec decB (
      .aLaw(aLawSel),
      .code(st.rxShift[7:0]),
      .sample(decSecond)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      logic clkRise;
      logic clkFall;
      logic frameStart;
      logic [10:0] cntNow;
      logic [5:0] bitsTotal;
      logic active;
      logic txGo;
      logic rxGo;
      logic bitEnd;
      clkRise = 1'b0;
      clkFall = 1'b0;
      frameStart = 1'b0;
      cntNow = 11'h000;
      bitsTotal = BITS_COMP;
      active = 1'b0;
      txGo = 1'b0;
      rxGo = 1'b0;
      bitEnd = 1'b0;
      next_st = st;

      // pins pass two flops and the bit clock a third; the second stage is looked at, and for the clock the third too
      next_st.clkS1 = bitClk;
      next_st.clkS2 = st.clkS1;
      next_st.clkPrev = st.clkS2;
      next_st.fsS1 = frameSync;
      next_st.fsS2 = st.fsS1;
      next_st.rxS1 = rxDataIn;
      next_st.rxS2 = st.rxS1;
      next_st.strapS1 = modeStrap;
      next_st.strapS2 = st.strapS1;
      next_st.txTake = 1'b0;
      next_st.rxValid = 1'b0;
      next_st.rxDone = 1'b0;

      // strap caught once, just after reset release
      if (!st.strapTaken) begin
         next_st.strapTaken = 1'b1;
         next_st.pcmMode = st.strapS2;
      end

      clkRise = st.clkS2 && !st.clkPrev;
      clkFall = !st.clkS2 && st.clkPrev;

      // 16 kHz doubles the samples per frame, frame rate unchanged
      if (linearSel) begin
         bitsTotal = highRate ? BITS_LIN_HR : BITS_LIN;
      end else begin
         bitsTotal = highRate ? BITS_COMP_HR : BITS_COMP;
      end

      ////////////////////////////////////////////////////////////////////////////////
      // frame timing from the bit clock

      if (clkRise) begin
         next_st.fsAtRise = st.fsS2;
         frameStart = st.fsS2 && !st.fsAtRise;
         if (frameStart) begin
            cntNow = 11'h000;
            // cycles per frame measured from sync to sync
            next_st.frameLen = st.cycleCnt + 11'h001;
            next_st.frameSeen = 1'b1;
            next_st.frameLocked = st.frameSeen;
         end else begin
            cntNow = (st.cycleCnt == CNT_MAX) ? CNT_MAX : st.cycleCnt + 11'h001;
         end
         next_st.cycleCnt = cntNow;
      end

      active = st.pcmMode && st.mode[MODE_EN_BIT] && st.frameLocked;
      // a start at or past the frame length never matches a cycle
      txGo = clkRise && active && cntNow == {1'b0, st.txStart} &&
             {1'b0, st.txStart} < next_st.frameLen;
      rxGo = clkRise && active && cntNow == {1'b0, st.rxStart} &&
             {1'b0, st.rxStart} < next_st.frameLen;

      ////////////////////////////////////////////////////////////////////////////////
      // transmit

      if (clkRise && st.txBusy) begin
         bitEnd = !dblClk || st.txPhase;
         if (!bitEnd) begin
            next_st.txPhase = 1'b1;
         end else if (st.txLeft == 6'h01) begin
            next_st.txBusy = 1'b0;
            next_st.txOe_n = 1'b1;
            next_st.txData = 1'b0;
         end else begin
            next_st.txPhase = 1'b0;
            next_st.txLeft = st.txLeft - 6'h01;
            next_st.txShift = {st.txShift[30:0], 1'b0};
            next_st.txData = st.txShift[30];
         end
      end

      // early release lets the next slot's driver start without contention
      if (clkFall && st.txBusy && st.txLeft == 6'h01 && st.mode[MODE_TRI_BIT] &&
          (!dblClk || st.txPhase)) begin
         next_st.txOe_n = 1'b1;
      end

      if (txGo) begin
         next_st.txBusy = 1'b1;
         next_st.txPhase = 1'b0;
         next_st.txLeft = bitsTotal;
         next_st.txTake = 1'b1;
         if (linearSel) begin
            // high byte first, first sample ahead of the second
            next_st.txShift = highRate ? {txSamples.first, txSamples.second}
                                       : {txSamples.first, 16'h0000};
         end else begin
            next_st.txShift = highRate ? {encFirst, encSecond, 16'h0000}
                                       : {encFirst, 24'h000000};
         end
         next_st.txData = linearSel ? txSamples.first[15] : encFirst[7];
         next_st.txOe_n = 1'b0;
      end

      ////////////////////////////////////////////////////////////////////////////////
      // receive

      if (clkFall && st.rxBusy) begin
         if (dblClk && !st.rxPhase) begin
            next_st.rxPhase = 1'b1;
         end else begin
            next_st.rxPhase = 1'b0;
            next_st.rxShift = {st.rxShift[30:0], st.rxS2};
            next_st.rxLeft = st.rxLeft - 6'h01;
            if (st.rxLeft == 6'h01) begin
               next_st.rxBusy = 1'b0;
               next_st.rxDone = 1'b1;
            end
         end
      end

      if (rxGo) begin
         next_st.rxBusy = 1'b1;
         next_st.rxPhase = 1'b0;
         next_st.rxLeft = bitsTotal;
         next_st.rxShift = 32'h00000000;
      end

      // decode from the settled shift register one cycle after the last bit
      if (st.rxDone) begin
         next_st.rxValid = 1'b1;
         if (linearSel) begin
            next_st.rxSamples.first = highRate ? st.rxShift[31:16] : st.rxShift[15:0];
            next_st.rxSamples.second = highRate ? st.rxShift[15:0] : 16'h0000;
         end else begin
            next_st.rxSamples.first = decFirst;
            next_st.rxSamples.second = highRate ? decSecond : 16'h0000;
         end
      end

      ////////////////////////////////////////////////////////////////////////////////
      // registers

      if (regReq.addrWrite) begin
         case (regReq.addr)
            REG_CTRL: next_st.ctrl = regReq.wrData;
            REG_MODE: next_st.mode = regReq.wrData;
            REG_TX_START_LO: next_st.txStart[7:0] = regReq.wrData;
            REG_TX_START_HI: next_st.txStart[9:8] = regReq.wrData[1:0];
            REG_RX_START_LO: next_st.rxStart[7:0] = regReq.wrData;
            REG_RX_START_HI: next_st.rxStart[9:8] = regReq.wrData[1:0];
            default: next_st.ctrl = st.ctrl;
         endcase
      end

      if (regReq.addrRead) begin
         case (regReq.addr)
            REG_CTRL: next_st.rdData = st.ctrl;
            REG_MODE: next_st.rdData = st.mode;
            REG_TX_START_LO: next_st.rdData = st.txStart[7:0];
            REG_TX_START_HI: next_st.rdData = {6'h00, st.txStart[9:8]};
            REG_RX_START_LO: next_st.rdData = st.rxStart[7:0];
            REG_RX_START_HI: next_st.rdData = {6'h00, st.rxStart[9:8]};
            REG_STATUS: begin
               next_st.rdData = 8'h00;
               next_st.rdData[STAT_PCM_BIT] = st.pcmMode;
               next_st.rdData[STAT_LOCK_BIT] = st.frameLocked;
               next_st.rdData[STAT_TX_BIT] = st.txBusy;
               next_st.rdData[STAT_RX_BIT] = st.rxBusy;
            end
            default: next_st.rdData = 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         st <= '0;
         // clock and strap sync stages run through reset: the strap is settled at release and no false clock edge follows
         st.clkS1 <= bitClk;
         st.clkS2 <= st.clkS1;
         st.clkPrev <= st.clkS2;
         st.strapS1 <= modeStrap;
         st.strapS2 <= st.strapS1;
         st.txOe_n <= 1'b1;
         st.ctrl <= CTRL_RESET;
         st.mode <= MODE_RESET;
         st.txStart <= START_RESET;
         st.rxStart <= START_RESET;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs straight from the state register

   assign regRdData = st.rdData;
   assign txDataOut = st.txData;
   assign txDataOe_n = st.txOe_n;
   assign txTake = st.txTake;
   assign rxSamples = st.rxSamples;
   assign rxValid = st.rxValid;

endmodule

// >>> bench/phw_port_sva.sv
module phw_port_sva (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // watched ports
   input phw_pkg::phw_reg_req_t regReq,
   input wire logic [7:0] regRdData,
   input wire logic bitClk,
   input wire logic txDataOut,
   input wire logic txDataOe_n,
   input wire logic txTake,
   input phw_pkg::phw_sample_pair_t rxSamples,
   input wire logic rxValid
);
   import phw_pkg::*;
   logic enNow;
   logic triSel;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////
   // shadow of the mode enable and tri bits; edge checks are skipped while disabled,
   // since the disabling write may change the tri and double bits under a sample still in flight
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         enNow <= 1'b0;
         triSel <= 1'b0;
      end else if (regReq.addrWrite && regReq.addr == REG_MODE) begin
         enNow <= regReq.wrData[MODE_EN_BIT];
         triSel <= regReq.wrData[MODE_TRI_BIT];
      end
   end
   ////////////////////////////////////////
   a_reset_quiet: assert property ($rose(rst_n) |-> txDataOe_n && !txDataOut && !txTake && !rxValid)
      else $error("outputs active after reset");
   a_take_drives: assert property (txTake |-> ##[0:2] !txDataOe_n)
      else $error("sample taken without driving");
   a_take_pulse: assert property (txTake |=> !txTake)
      else $error("take longer than one cycle");
   a_valid_pulse: assert property (rxValid |=> !rxValid)
      else $error("valid longer than one cycle");
   a_rx_held: assert property (!rxValid |-> $stable(rxSamples))
      else $error("rx samples changed without valid");
   a_tx_edge: assert property ($changed(txDataOut) && enNow && !txDataOe_n |-> $past(bitClk, 3))
      else $error("tx bit changed off the rising edge");
   a_release_edge: assert property ($rose(txDataOe_n) && enNow |-> $past(bitClk, 3) == !triSel)
      else $error("tx released on the wrong edge");
   a_start_width: assert property (regReq.addrRead && regReq.addr == REG_TX_START_HI |=> regRdData[7:2] == 6'h00)
      else $error("start count wider than ten bits");
endmodule
bind phw_port phw_port_sva i_sva (.core_clk(core_clk), .rst_n(rst_n), .regReq(regReq), .regRdData(regRdData),
   .bitClk(bitClk), .txDataOut(txDataOut), .txDataOe_n(txDataOe_n), .txTake(txTake), .rxSamples(rxSamples),
   .rxValid(rxValid));

// >>> bench/phw_highway_host.sv
module phw_highway_host (
   // frame options and receive pattern
   input wire logic fsLong,
   input wire logic [63:0] rxFrame,
   // highway pins
   input wire logic txDataOut,
   input wire logic txDataOe_n,
   output logic bitClk,
   output logic frameSync,
   output logic rxDataIn,
   // what the port drove in the last whole frame
   output logic [63:0] txWord,
   output logic [63:0] txDrv,
   output int frames
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [63:0] bits;
   logic [63:0] drv;
   initial begin
      {bitClk, frameSync, rxDataIn} = 3'h0;
      {txWord, txDrv, bits, drv} = '0;
      frames = 0;
      #3;
      // free running, eight byte slots per frame
      forever begin
         for (int k = 0; k < 64; k++) begin
            bitClk = 1'b1;
            frameSync = (k == 0) || (fsLong && k < 8);
            rxDataIn = rxFrame[63 - k];
            #40;
            bitClk = 1'b0;
            bits[63 - k] = txDataOut;
            drv[63 - k] = !txDataOe_n;
            #40;
         end
         txWord = bits;
         txDrv = drv;
         frames++;
      end
   end
endmodule

// >>> bench/tb_top.sv
module tb_top;
   import phw_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk, rst_n, modeStrap, fsLong;
   phw_reg_req_t regReq;
   phw_sample_pair_t txSamples, rxSamples, rxGot;
   logic [7:0] regRdData, v;
   logic bitClk, frameSync, rxDataIn, txDataOut, txDataOe_n, txTake, rxValid;
   logic [63:0] rxFrame, txWord, txDrv;
   logic [31:0] seed, sx, rx;
   logic [41:0] ent;
   int frames, rxSeen, miscompares, comparisons, caseNo, n, st, rs;
   // format, sample, code, decoded sample
   localparam logic [41:0] CTAB [6] = '{{2'h0, 16'h0000, 8'hff, 16'h0000}, {2'h0, 16'h7f7c, 8'h80, 16'h7d7c},
      {2'h0, 16'h8084, 8'h00, 16'h8284}, {2'h1, 16'h0000, 8'hd5, 16'h0008}, {2'h1, 16'h7ff8, 8'haa, 16'h7e00},
      {2'h1, 16'h8008, 8'h2a, 16'h8200}};
   phw_port i_dut (.core_clk(core_clk), .rst_n(rst_n), .modeStrap(modeStrap), .regReq(regReq),
      .regRdData(regRdData), .bitClk(bitClk), .frameSync(frameSync), .rxDataIn(rxDataIn), .txDataOut(txDataOut),
      .txDataOe_n(txDataOe_n), .txSamples(txSamples), .txTake(txTake), .rxSamples(rxSamples), .rxValid(rxValid));
   phw_highway_host i_host (.fsLong(fsLong), .rxFrame(rxFrame), .txDataOut(txDataOut), .txDataOe_n(txDataOe_n),
      .bitClk(bitClk), .frameSync(frameSync), .rxDataIn(rxDataIn), .txWord(txWord), .txDrv(txDrv), .frames(frames));
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   always @(negedge core_clk) begin
      if (rxValid === 1'b1) begin
         rxGot <= rxSamples;
         rxSeen <= rxSeen + 1;
      end
   end
   ////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // bit clock positions of a msb-first sample; inv spoils the unsampled half of a doubled bit
   function automatic logic [63:0] place(input logic [31:0] b, input int n, input int st, input logic dbl,
      input logic inv);
      logic [63:0] w;
      int p;
      w = '0;
      for (int i = 0; i < n; i++) begin
         for (int d = 0; d <= int'(dbl); d++) begin
            p = st + i * (dbl ? 2 : 1) + d;
            if (p < 64) w[63 - p] = b[n - 1 - i] ^ (inv && dbl && d == 0);
         end
      end
      return w;
   endfunction
   task automatic chk_word(input string what, input logic [63:0] e, input logic [63:0] g);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic chk_reg(input string what, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic reg_wr(input logic [5:0] a, input logic [7:0] d);
      regReq = '{addrWrite: 1'b1, addrRead: 1'b0, addr: a, wrData: d};
      @(negedge core_clk);
      regReq.addrWrite = 1'b0;
      @(negedge core_clk);
   endtask
   task automatic reg_rd(input logic [5:0] a, output logic [7:0] d);
      regReq = '{addrWrite: 1'b0, addrRead: 1'b1, addr: a, wrData: 8'h00};
      @(negedge core_clk);
      regReq.addrRead = 1'b0;
      @(negedge core_clk);
      d = regRdData;
   endtask
   task automatic wait_frames(input int k);
      repeat (k) @(frames);
      repeat (20) @(negedge core_clk);
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic run_case(input logic on, input logic [1:0] fmt, input logic dbl, input logic tr, input logic hr,
      input logic [9:0] tx_slot_start, input logic [9:0] rx_slot_start, input logic [31:0] txExp, input logic [31:0] rxBits,
      input phw_sample_pair_t rxExp);
      int n;
      logic [63:0] m;
      n = (fmt == FMT_LINEAR ? 16 : 8) * (hr ? 2 : 1);
      m = place(32'hffffffff, n, rx_slot_start, dbl, 1'b0);
      seed = lfsr(seed);
      rxFrame = (place(rxBits, n, rx_slot_start, dbl, 1'b1) & m) | ({seed, ~seed} & ~m);
      // disable first so no transfer sees a half written setup
      reg_wr(REG_MODE, 8'h00);
      reg_wr(REG_CTRL, {4'h0, hr, 3'h0});
      reg_wr(REG_TX_START_LO, tx_slot_start[7:0]);
      reg_wr(REG_TX_START_HI, {6'h00, tx_slot_start[9:8]});
      reg_wr(REG_RX_START_LO, rx_slot_start[7:0]);
      reg_wr(REG_RX_START_HI, {6'h00, rx_slot_start[9:8]});
      reg_wr(REG_MODE, {2'h0, 1'b1, 1'b0, fmt, tr, dbl});
      wait_frames(2);
      rxSeen = 0;
      wait_frames(1);
      m = (on && tx_slot_start < 64) ? place(32'hffffffff, n, tx_slot_start, dbl, 1'b0) : 64'h0;
      chk_word("tx drive", m, txDrv);
      chk_word("tx bits", place(txExp, n, tx_slot_start, dbl, 1'b0) & m, txWord & m);
      chk_word("rx count", 64'(on && rx_slot_start < 64), 64'(rxSeen));
      if (on && rx_slot_start < 64) chk_word("rx sample", {32'h0, rxExp}, {32'h0, rxGot});
      $display("case %0d done", caseNo);
      caseNo++;
   endtask
   ////////////////////////////////////////
   initial begin
      #600000;
      $display("watchdog expired");
      miscompares++;
      tally_and_finish;
   end
   initial begin
      {rst_n, fsLong, modeStrap} = 3'h1;
      {regReq, txSamples, rxFrame, rxGot} = '0;
      {miscompares, comparisons, rxSeen, caseNo} = '0;
      seed = 32'hc0899d4a;
      repeat (16) @(negedge core_clk);
      rst_n = 1'b1;
      reg_rd(REG_MODE, v);
      chk_reg("mode after reset", MODE_RESET, v);
      reg_wr(REG_TX_START_HI, 8'hff);
      reg_rd(REG_TX_START_HI, v);
      chk_reg("start high byte", 8'h03, v);
      reg_wr(6'h10, 8'h5a);
      reg_rd(6'h10, v);
      chk_reg("unmapped read", 8'h00, v);
      wait_frames(2);
      reg_rd(REG_STATUS, v);
      chk_reg("status", 8'h03, v & 8'h03);
      for (int i = 0; i < 4; i++) begin
         fsLong = i[0];
         seed = lfsr(seed);
         sx = seed;
         seed = lfsr(seed);
         rx = seed;
         n = 16 * (1 + i[1]) * (1 + i[0]);
         st = (i == 0) ? 0 : int'(seed[9:0]) % (65 - n);
         rs = (i == 0) ? 0 : int'(seed[19:10]) % (65 - n);
         txSamples = sx;
         run_case(1'b1, FMT_LINEAR, i[0], sx[0], i[1], 10'(st), 10'(rs), i[1] ? sx : {16'h0, sx[31:16]},
            i[1] ? rx : {16'h0, rx[15:0]}, i[1] ? rx : {rx[15:0], 16'h0});
      end
      fsLong = 1'b0;
      for (int i = 0; i < 6; i++) begin
         ent = CTAB[i];
         seed = lfsr(seed);
         n = 8 * (1 + i[0]);
         txSamples = {ent[39:24], ent[39:24]};
         run_case(1'b1, ent[41:40], 1'b0, seed[6], i[0], 10'(int'(seed[5:0]) % (65 - n)), 10'(64 - n),
            i[0] ? {16'h0, {2{ent[23:16]}}} : {24'h0, ent[23:16]}, i[0] ? {16'h0, {2{ent[23:16]}}} :
            {24'h0, ent[23:16]}, {ent[15:0], i[0] ? ent[15:0] : 16'h0});
      end
      fsLong = 1'b1;
      run_case(1'b1, FMT_LINEAR, 1'b0, 1'b1, 1'b0, 10'd64, 10'h3ff, 32'h0, 32'h0, '0);
      rst_n = 1'b0;
      modeStrap = 1'b0;
      repeat (16) @(negedge core_clk);
      rst_n = 1'b1;
      wait_frames(2);
      reg_rd(REG_STATUS, v);
      chk_reg("status strap low", 8'h02, v & 8'h03);
      run_case(1'b0, FMT_LINEAR, 1'b0, 1'b1, 1'b0, 10'd0, 10'd0, 32'h0, 32'h0, '0);
      tally_and_finish;
   end
endmodule
